// File: pkg/at_cmd_consts.vh
// Purpose: Shared constants for the command-mode front end.
// Assumes: 25 MHz aclk; times are counted in millisecond ticks.
// Notes:   Included by bare name; definitions only.
`ifndef AT_CMD_CONSTS_VH
`define AT_CMD_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ      25
`define TICK_US      1000
`define BREAK_MS     13'd6000
`define CT_UNIT_MS   7'd100

// ****************************************
// Parameter table: index and factory default
// ****************************************
`define P_GUARD      3'd0
`define P_CHAR       3'd1
`define P_TIMEOUT    3'd2
`define P_BAUD       3'd3
`define P_FRAME      3'd4
`define P_OUTOPT     3'd5
`define NPARAM       6
`define DEF_GUARD    16'h03e8
`define DEF_CHAR     16'h002b
`define DEF_TIMEOUT  16'h0064
`define DEF_BAUD     16'h0003
`define DEF_FRAME    16'h0000
`define DEF_OUTOPT   16'h0000
`define BAUD_BREAK   4'h3

// ****************************************
// Register map, word indices (byte address bits 4:2)
// ****************************************
`define A_STATUS     3'd0
`define A_CTRL       3'd7
`define CTRL_APPLY   0
`define CTRL_SAVE    1
`define AXI_OKAY     2'b00
`define AXI_SLVERR   2'b10

// ****************************************
// Command identifiers, two upper-case letters
// ****************************************
`define ID_GUARD     16'h4754
`define ID_CHAR      16'h4343
`define ID_TIMEOUT   16'h4354
`define ID_BAUD      16'h4244
`define ID_FRAME     16'h4150
`define ID_OUTOPT    16'h414f
`define ID_EXIT      16'h434e
`define ID_APPLY     16'h4143
`define ID_SAVE      16'h5752
`define ID_DEFAULTS  16'h5245
`define OP_EXIT      4'd8
`define OP_APPLY     4'd9
`define OP_SAVE      4'd10
`define OP_DEFAULTS  4'd11
`define OP_NONE      4'd15

// ****************************************
// Characters and replies
// ****************************************
`define CH_A         8'h41
`define CH_T         8'h54
`define CH_CR        8'h0d
`define CH_COMMA     8'h2c
`define CH_X         8'h58
`define CH_SPACE     8'h20
`define CH_O         8'h4f
`define CH_K         8'h4b
`define CH_E         8'h45
`define CH_R         8'h52
`define CH_0         8'h30
`define HEX_A_OFS    8'h37
`define CASE_MASK    8'hdf
`define R_OK         2'd0
`define R_ERR        2'd1
`define R_VAL        2'd2
`define LEN_OK       3'd3
`define LEN_ERR      3'd6
`define LEN_VAL      3'd5
`define MAX_DIGITS   3'd4

`endif

// File: rtl/at_command_mode_interp.v
// Purpose: Command-mode front end of a serial radio module.
// Assumes: Byte-level UART in front; synchronous inputs.
// Notes:   Registers reached over AXI4-Lite.
`timescale 1ns/1ps
`include "at_cmd_consts.vh"

module at_command_mode_interp #(
  parameter TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  // Clock, reset and power-on.
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        por,
  // AXI4-Lite write channels.
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read channels.
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // UART byte side.
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_break,
  input  wire        rts,
  output reg  [7:0]  tx_data,
  output wire        tx_valid,
  input  wire        tx_ready,
  // Radio side.
  output reg  [7:0]  fwd_data,
  output reg         fwd_valid,
  input  wire        rf_rx_busy,
  input  wire        rf_tx_busy,
  // Mode outputs.
  output reg         cmd_mode,
  output reg         boot_req,
  output reg  [3:0]  baud_code,
  output reg  [3:0]  op_state,
  output reg         out_full_packet,
  output reg         out_raw_objects
);

  // Parser states.
  localparam P_A   = 5'b00001;
  localparam P_T   = 5'b00010;
  localparam P_ID1 = 5'b00100;
  localparam P_ID2 = 5'b01000;
  localparam P_ARG = 5'b10000;
  // Operating states.
  localparam S_IDLE = 4'b0001;
  localparam S_TX   = 4'b0010;
  localparam S_RX   = 4'b0100;
  localparam S_CMD  = 4'b1000;
  localparam [14:0] TICK_LAST = TICK_CYCLES[14:0] - 15'd1;

  // ****************************************
  // Helper functions
  // ****************************************
  // Factory default of one parameter entry.
  function [15:0] dflt(input [2:0] i);
    begin
      case (i)
        `P_GUARD:   dflt = `DEF_GUARD;
        `P_CHAR:    dflt = `DEF_CHAR;
        `P_TIMEOUT: dflt = `DEF_TIMEOUT;
        `P_BAUD:    dflt = `DEF_BAUD;
        `P_FRAME:   dflt = `DEF_FRAME;
        default:    dflt = `DEF_OUTOPT;
      endcase
    end
  endfunction

  // Two-letter identifier to operation code.
  function [3:0] op_of(input [15:0] id);
    begin
      case (id)
        `ID_GUARD:    op_of = {1'b0, `P_GUARD};
        `ID_CHAR:     op_of = {1'b0, `P_CHAR};
        `ID_TIMEOUT:  op_of = {1'b0, `P_TIMEOUT};
        `ID_BAUD:     op_of = {1'b0, `P_BAUD};
        `ID_FRAME:    op_of = {1'b0, `P_FRAME};
        `ID_OUTOPT:   op_of = {1'b0, `P_OUTOPT};
        `ID_EXIT:     op_of = `OP_EXIT;
        `ID_APPLY:    op_of = `OP_APPLY;
        `ID_SAVE:     op_of = `OP_SAVE;
        `ID_DEFAULTS: op_of = `OP_DEFAULTS;
        default:      op_of = `OP_NONE;
      endcase
    end
  endfunction

  // Hex digit value, bit 4 flags a valid digit.
  function [4:0] hexval(input [7:0] c);
    begin
      if (c >= `CH_0 && c <= 8'h39)
        hexval = {1'b1, c[3:0]};
      else if ((c & `CASE_MASK) >= 8'h41 && (c & `CASE_MASK) <= 8'h46)
        hexval = {1'b1, c[3:0] + 4'h9};
      else
        hexval = 5'h00;
    end
  endfunction

  // Byte i of a reply of kind k; value replies print four hex digits.
  function [7:0] resp_byte(input [1:0] k, input [2:0] i, input [15:0] v);
    reg [3:0] n;
    begin
      case (i)
        3'd0:    n = v[15:12];
        3'd1:    n = v[11:8];
        3'd2:    n = v[7:4];
        default: n = v[3:0];
      endcase
      resp_byte = `CH_CR;
      if (k == `R_OK) begin
        if (i == 3'd0) resp_byte = `CH_O;
        else if (i == 3'd1) resp_byte = `CH_K;
      end else if (k == `R_ERR) begin
        if (i == 3'd0) resp_byte = `CH_E;
        else if (i == 3'd3) resp_byte = `CH_O;
        else if (i < 3'd5) resp_byte = `CH_R;
      end else if (i < 3'd4) begin
        resp_byte = (n < 4'ha) ? `CH_0 + {4'h0, n} : `HEX_A_OFS + {4'h0, n};
      end
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  wire [16*`NPARAM-1:0] act_bus;
  wire [16*`NPARAM-1:0] pend_bus;
  reg  [14:0] pre;
  reg  [15:0] sil;
  reg  [12:0] brk_ms;
  reg  [1:0]  esc_n;
  reg         rst_done;
  reg  [6:0]  ct_ms;
  reg  [15:0] ct_units;
  reg  [4:0]  ps;
  reg  [7:0]  id_hi;
  reg  [7:0]  id_lo;
  reg  [15:0] acc;
  reg  [2:0]  ndig;
  reg         bad;
  reg  [1:0]  rk;
  reg  [2:0]  ri;
  reg  [2:0]  rl;
  reg  [15:0] rv;
  reg         aw_got;
  reg         w_got;
  reg  [7:0]  aw_a;
  reg  [15:0] w_d;
  reg  [1:0]  w_s;
  reg  [1:0]  ctl_d;
  reg  [1:0]  next_k;
  reg  [15:0] next_v;

  wire [15:0] gt = act_bus[16*`P_GUARD +: 16];
  wire [7:0]  cc = act_bus[16*`P_CHAR +: 8];
  wire [15:0] ct = act_bus[16*`P_TIMEOUT +: 16];
  wire        tick = (pre == TICK_LAST);
  wire [4:0]  hv = hexval(rx_data);
  wire [7:0]  ub = rx_data & `CASE_MASK;
  wire        term = rx_data == `CH_CR || rx_data == `CH_COMMA;
  wire [3:0]  op = op_of({id_hi, id_lo});
  wire        exec = cmd_mode & rx_valid & (ps == P_ARG) & term;
  wire        bare = cmd_mode & rx_valid & (ps == P_ID1) & term;
  wire        err = bad | (op == `OP_NONE) | (ndig > `MAX_DIGITS);
  wire        ok = exec & ~err;
  wire        is_par = ~op[3];
  wire        at_we = ok & is_par & (ndig != 3'd0);
  wire        axi_we = aw_got & w_got & ~bvalid;
  wire [2:0]  w_idx = aw_a[4:2];
  wire        w_map = (aw_a[7:5] == 3'd0);
  wire        axi_pw = axi_we & w_map & (w_idx != `A_STATUS) & (w_idx != `A_CTRL);
  wire        axi_cw = axi_we & w_map & (w_idx == `A_CTRL);
  wire [15:0] w_mask = {{8{w_s[1]}}, {8{w_s[0]}}};
  wire [15:0] w_old = pend_bus[16*(w_idx - 3'd1) +: 16];
  wire [15:0] w_val = (w_d & w_mask) | (w_old & ~w_mask);
  wire        tmo = cmd_mode & ~rx_valid & (ct_units >= ct);
  wire        leave = (ok & (op == `OP_EXIT)) | tmo;
  wire        do_apply = (ok & (op == `OP_APPLY)) | leave | (axi_cw & ctl_d[`CTRL_APPLY]);
  wire        do_save = (ok & (op == `OP_SAVE)) | (axi_cw & ctl_d[`CTRL_SAVE]);
  wire        do_defaults = ok & (op == `OP_DEFAULTS);
  wire        brk_evt = (~rst_done & rx_break) | (rx_break & tick & (brk_ms == `BREAK_MS - 13'd1));
  wire        enter_esc = ~cmd_mode & (esc_n == 2'd3) & ~rx_valid & (sil >= gt);
  wire        enter = enter_esc | (brk_evt & rts);

  assign awready = ~aw_got & ~bvalid;
  assign wready = ~w_got & ~bvalid;
  assign arready = ~rvalid;
  assign tx_valid = (ri != rl);

  // ****************************************
  // Parameter entries
  // ****************************************
  // Each entry keeps stored, pending and active copies of one setting.
  genvar g;
  generate
    for (g = 0; g < `NPARAM; g = g + 1) begin : gen_par
      reg [15:0] a;
      reg [15:0] p;
      reg [15:0] n;
      assign act_bus[16*g +: 16] = a;
      assign pend_bus[16*g +: 16] = p;
      always @(posedge aclk) begin
        if (por)
          n <= dflt(g);
        else if (aresetn && do_save)
          n <= p;
      end
      always @(posedge aclk) begin
        if (por) begin
          a <= dflt(g);
          p <= dflt(g);
        end else if (!aresetn) begin
          a <= n;
          p <= n;
        end else begin
          if (do_defaults)
            p <= dflt(g);
          if (at_we && op[2:0] == g)
            p <= acc;
          if (axi_pw && w_idx == g + 1)
            p <= w_val;
          if (do_apply)
            a <= p;
        end
      end
    end
  endgenerate

  // ****************************************
  // Timers
  // ****************************************
  // Millisecond tick, guard silence and break length.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre <= 15'd0;
      sil <= 16'd0;
      brk_ms <= 13'd0;
    end else begin
      pre <= tick ? 15'd0 : pre + 15'd1;
      if (rx_valid)
        sil <= 16'd0;
      else if (tick && sil != 16'hffff)
        sil <= sil + 16'd1;
      if (!rx_break)
        brk_ms <= 13'd0;
      else if (tick && brk_ms != `BREAK_MS)
        brk_ms <= brk_ms + 13'd1;
    end
  end

  // Command timeout counts in units of one tenth of a second.
  // command mode timeout.
  always @(posedge aclk) begin
    if (!aresetn || !cmd_mode || rx_valid) begin
      ct_ms <= 7'd0;
      ct_units <= 16'd0;
    end else if (tick) begin
      if (ct_ms == `CT_UNIT_MS - 7'd1) begin
        ct_ms <= 7'd0;
        if (ct_units != 16'hffff)
          ct_units <= ct_units + 16'd1;
      end else begin
        ct_ms <= ct_ms + 7'd1;
      end
    end
  end

  // ****************************************
  // Escape detection and mode control
  // ****************************************
  // consecutive escape bytes.
  // The leading byte needs full guard silence, the next two need less.
  always @(posedge aclk) begin
    if (!aresetn || cmd_mode || enter)
      esc_n <= 2'd0;
    else if (rx_valid) begin
      if (rx_data == cc && esc_n == 2'd0 && sil >= gt)
        esc_n <= 2'd1;
      else if (rx_data == cc && esc_n != 2'd0 && esc_n != 2'd3 && sil < gt)
        esc_n <= esc_n + 2'd1;
      else
        esc_n <= 2'd0;
    end
  end

  // guard framed entry.
  // Break checks need RTS; without it the bootloader request latches.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_mode <= 1'b0;
      boot_req <= 1'b0;
      rst_done <= 1'b0;
      baud_code <= `BAUD_BREAK;
    end else begin
      rst_done <= 1'b1;
      if (brk_evt && !rts)
        boot_req <= 1'b1;
      if (enter) begin
        cmd_mode <= 1'b1;
        if (brk_evt)
          baud_code <= `BAUD_BREAK;
      end else if (leave) begin
        cmd_mode <= 1'b0;
        baud_code <= act_bus[16*`P_BAUD +: 4];
      end else if (!cmd_mode) begin
        baud_code <= act_bus[16*`P_BAUD +: 4];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      fwd_valid <= 1'b0;
      fwd_data <= 8'h00;
    end else begin
      fwd_valid <= rx_valid & ~cmd_mode;
      fwd_data <= rx_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      op_state <= S_IDLE;
      out_full_packet <= 1'b0;
      out_raw_objects <= 1'b0;
    end else begin
      if (cmd_mode)
        op_state <= S_CMD;
      else if (rf_rx_busy)
        op_state <= S_RX;
      else if (rf_tx_busy)
        op_state <= S_TX;
      else
        op_state <= S_IDLE;
      out_full_packet <= act_bus[16*`P_FRAME +: 16] != 16'h0000;
      out_raw_objects <= act_bus[16*`P_FRAME +: 16] != 16'h0000 && act_bus[16*`P_OUTOPT];
    end
  end

  // ****************************************
  // Command parser
  // ****************************************
  // AT prefix expected.
  always @(posedge aclk) begin
    if (!aresetn || !cmd_mode) begin
      ps <= P_A;
      id_hi <= 8'h00;
      id_lo <= 8'h00;
      acc <= 16'h0000;
      ndig <= 3'd0;
      bad <= 1'b0;
    end else if (rx_valid) begin
      case (ps)
        P_A: begin
          if (ub == `CH_A) ps <= P_T;
        end
        P_T: begin
          ps <= (ub == `CH_T) ? P_ID1 : P_A;
        end
        P_ID1: begin
          id_hi <= ub;
          ps <= term ? P_A : P_ID2;
        end
        P_ID2: begin
          id_lo <= ub;
          acc <= 16'h0000;
          ndig <= 3'd0;
          bad <= 1'b0;
          ps <= P_ARG;
        end
        P_ARG: begin
          if (term) begin
            ps <= (rx_data == `CH_COMMA) ? P_ID1 : P_A;
          end else if (ub == `CH_X && ndig == 3'd1 && acc == 16'h0000) begin
            ndig <= 3'd0;
          end else if (hv[4]) begin
            acc <= {acc[11:0], hv[3:0]};
            if (ndig != 3'd7) ndig <= ndig + 3'd1;
          end else if (!(rx_data == `CH_SPACE && ndig == 3'd0)) begin
            bad <= 1'b1;
          end
        end
        default: ps <= P_A;
      endcase
    end
  end

  // ****************************************
  // Replies
  // ****************************************
  // read without value.
  always @* begin
    next_v = 16'h0000;
    if (is_par)
      next_v = pend_bus[16*op[2:0] +: 16];
    if (err)
      next_k = `R_ERR;
    else if (is_par && ndig == 3'd0)
      next_k = `R_VAL;
    else
      next_k = `R_OK;
  end

  // OK on entry.
  // A new reply replaces one still draining; hosts wait for the answer.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rk <= `R_OK;
      ri <= 3'd0;
      rl <= 3'd0;
      rv <= 16'h0000;
      tx_data <= 8'h00;
    end else if (enter || bare) begin
      rk <= `R_OK;
      ri <= 3'd0;
      rl <= `LEN_OK;
      tx_data <= `CH_O;
    end else if (exec) begin
      rk <= next_k;
      rv <= next_v;
      ri <= 3'd0;
      rl <= (next_k == `R_OK) ? `LEN_OK : (next_k == `R_ERR) ? `LEN_ERR : `LEN_VAL;
      tx_data <= resp_byte(next_k, 3'd0, next_v);
    end else if (tx_valid && tx_ready) begin
      ri <= ri + 3'd1;
      tx_data <= resp_byte(rk, ri + 3'd1, rv);
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Address and data are latched in either order; the write commits once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 16'h0000;
      w_s <= 2'b00;
      ctl_d <= 2'b00;
      bvalid <= 1'b0;
      bresp <= `AXI_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_d <= wdata[15:0];
        w_s <= wstrb[1:0];
        ctl_d <= wdata[1:0] & {2{wstrb[0]}};
      end
      if (axi_we) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= w_map ? `AXI_OKAY : `AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Reads return active values; status shows mode flags.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= (araddr[7:5] == 3'd0) ? `AXI_OKAY : `AXI_SLVERR;
      if (araddr[7:5] != 3'd0 || araddr[4:2] == `A_CTRL)
        rdata <= 32'h0000_0000;
      else if (araddr[4:2] == `A_STATUS)
        rdata <= {24'h000000, baud_code, op_state[1:0], boot_req, cmd_mode};
      else
        rdata <= {16'h0000, act_bus[16*(araddr[4:2] - 3'd1) +: 16]};
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: tb/uart_host_model.sv
// Purpose: Host terminal model on the UART byte side.
// Assumes: Bytes move at rising aclk.
// Notes:   Stalls the reply path on every other cycle.
`timescale 1ns/1ps
module uart_host_model (
  // Clock.
  input  wire       aclk,
  // Byte lines.
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready
);
  logic [7:0] q[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // host sends bytes
  // Idle data is inverted so a stale byte never looks valid.
  task send(input string s, input int gap);
    int i;
    for (i = 0; i < s.len(); i++) begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_data <= ~s[i];
      repeat (gap) @(posedge aclk);
    end
  endtask
  // Alternate stalls force the reply path to hold each byte.
  always @(posedge aclk) begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready)
      q.push_back(tx_data);
  end
endmodule

// File: tb/at_command_mode_interp_asserts.sv
// Purpose: Port checker for the command-mode front end.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Attached by bind below.
`timescale 1ns/1ps
module at_command_mode_checker (
  // Clock and reset.
  input wire       aclk,
  input wire       aresetn,
  // Watched ports.
  input wire [7:0] araddr,
  input wire       arvalid,
  input wire       arready,
  input wire       rvalid,
  input wire [1:0] rresp,
  input wire [7:0] rx_data,
  input wire       rx_valid,
  input wire       rx_break,
  input wire [7:0] tx_data,
  input wire       tx_valid,
  input wire [7:0] fwd_data,
  input wire       fwd_valid,
  input wire       cmd_mode,
  input wire       boot_req,
  input wire [3:0] baud_code,
  input wire [3:0] op_state,
  input wire       out_full_packet,
  input wire       out_raw_objects
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fwd_blocked: assert property (rx_valid && cmd_mode |=> !fwd_valid)
    else $error("byte forwarded in command mode");
  a_fwd_passes: assert property (rx_valid && !cmd_mode |=> fwd_valid && fwd_data == $past(rx_data))
    else $error("byte not forwarded");
  a_entry_ok: assert property ($rose(cmd_mode) |-> ##[0:1] (tx_valid && tx_data == 8'h4f))
    else $error("entry without reply");
  a_break_baud: assert property ($rose(cmd_mode) && $past(rx_break) |-> baud_code == 4'h3)
    else $error("break entry baud wrong");
  a_boot_hold: assert property (boot_req |=> boot_req)
    else $error("boot request dropped");
  a_boot_excl: assert property ($rose(boot_req) |-> !$rose(cmd_mode))
    else $error("boot and command entry together");
  a_op_cmd: assert property (cmd_mode [*2] |-> op_state == 4'b1000)
    else $error("state not command");
  a_op_onehot: assert property ($onehot(op_state))
    else $error("state not one-hot");
  a_raw_frame: assert property (out_raw_objects |-> out_full_packet)
    else $error("raw output without frames");
  a_rd_err: assert property (arvalid && arready && araddr[7:5] != 3'd0 |=> rvalid && rresp == 2'b10)
    else $error("unmapped read not refused");
  cover property ($rose(cmd_mode));
  cover property ($rose(boot_req));
  cover property (rvalid && rresp == 2'b10);
endmodule
bind at_command_mode_interp at_command_mode_checker chk_i (.*);

// File: tb/test_at_command_mode_interp.sv
// Purpose: Self-checking bench for the command-mode front end.
// Assumes: Millisecond tick shortened to two cycles.
// Notes:   Guard, timeout and break waits below are derived from that tick.
`timescale 1ns/1ps
module test_at_command_mode_interp;
  localparam TK = 2;
  localparam SIL = 1000 * TK + 4 * TK;
  reg aclk, aresetn, por, awvalid, wvalid, bready, arvalid, rready, rx_break, rts, rf_rx_busy, rf_tx_busy;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, fwd_valid;
  wire cmd_mode, boot_req, out_full_packet, out_raw_objects;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] rx_data, tx_data, fwd_data;
  wire [3:0] baud_code, op_state;
  logic [31:0] q;
  logic [1:0] r;
  int fail_count, cmp_count;
  at_command_mode_interp #(.TICK_CYCLES(TK)) uut (.*);
  uart_host_model hst (.*);
  // ****************************************
  // Tasks
  // ****************************************
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One transfer; write channels are released as each is taken.
  task axi(input bit wr, input [7:0] a, input [31:0] d);
    int i;
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (bvalid || rvalid)
        break;
    end
    q = rdata;
    r = wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
    if (i == 100) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Replies are collected by the host model, then compared in order.
  task reply(input string s);
    int i;
    for (i = 0; i < 4000 && hst.q.size() < s.len(); i++)
      @(posedge aclk);
    if (hst.q.size() < s.len()) begin
      fail_count++;
      stop_test();
    end
    for (i = 0; i < s.len(); i++)
      chk("reply", s[i], hst.q.pop_front());
    chk("reply_extra", 0, hst.q.size());
  endtask
  task rst;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    por <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rx_break, rf_rx_busy, rf_tx_busy} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    rts = 1'b1;
    por = 1'b1;
    aresetn = 1'b0;
    rst();
    chk("baud", 3, baud_code);
    chk("op_state", 1, op_state);
    axi(0, 8'h04, 0);
    chk("guard", 16'h03e8, q);
    axi(0, 8'h20, 0);
    chk("rresp", 2'b10, r);
    $display("test reset done");
    repeat (SIL) @(posedge aclk);
    hst.send("+++", 1);
    repeat (SIL) @(posedge aclk);
    reply("OK\r");
    chk("cmd_mode", 1, cmd_mode);
    hst.send("ATBD0x5\r", 1);
    reply("OK\r");
    chk("baud", 3, baud_code);
    hst.send("ATBD\r", 1);
    reply("0005\r");
    hst.send("ATXY\r", 1);
    reply("ERROR\r");
    hst.send("ATCC31,CN\r", 8);
    reply("OK\rOK\r");
    chk("cmd_mode", 0, cmd_mode);
    chk("baud", 5, baud_code);
    $display("test escape done");
    repeat (SIL) @(posedge aclk);
    hst.send("111", 1);
    repeat (SIL) @(posedge aclk);
    reply("OK\r");
    repeat (10000 * TK + 40 * TK) @(posedge aclk);
    chk("timeout", 0, cmd_mode);
    hst.send("111\r", 1);
    repeat (SIL) @(posedge aclk);
    chk("cancel", 0, cmd_mode);
    chk("cancel_q", 0, hst.q.size());
    $display("test timeout done");
    rx_break <= 1'b1;
    repeat (6000 * TK + 4 * TK) @(posedge aclk);
    rx_break <= 1'b0;
    reply("OK\r");
    chk("brk_baud", 3, baud_code);
    hst.send("ATCN\r", 1);
    reply("OK\r");
    chk("baud", 5, baud_code);
    rts <= 1'b0;
    rx_break <= 1'b1;
    repeat (6000 * TK + 4 * TK) @(posedge aclk);
    chk("boot", 1, boot_req);
    chk("no_cmd", 0, cmd_mode);
    rts <= 1'b1;
    rst();
    chk("rst_cmd", 1, cmd_mode);
    chk("boot_clr", 0, boot_req);
    rx_break <= 1'b0;
    reply("OK\r");
    $display("test break done");
    axi(1, 8'h14, 1);
    chk("bresp", 0, r);
    axi(1, 8'h18, 1);
    axi(1, 8'h1c, 1);
    chk("full_pkt", 1, out_full_packet);
    chk("raw", 1, out_raw_objects);
    axi(0, 8'h00, 0);
    chk("status", 32'h31, q);
    $display("test frame done");
    hst.send("ATGT5DC,WR\r", 8);
    reply("OK\rOK\r");
    rx_break <= 1'b1;
    rst();
    rx_break <= 1'b0;
    reply("OK\r");
    axi(0, 8'h04, 0);
    chk("saved_guard", 16'h05dc, q);
    hst.send("ATRE,WR\r", 8);
    reply("OK\rOK\r");
    rst();
    axi(0, 8'h04, 0);
    chk("dflt_guard", 16'h03e8, q);
    $display("test save done");
    rf_rx_busy <= 1'b1;
    rf_tx_busy <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("op_rx", 4, op_state);
    rf_rx_busy <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("op_tx", 2, op_state);
    $display("test state done");
    stop_test();
  end
endmodule
